// File: src/wdc_core.sv
`include "wdc_cfg.svh"

module wdc_core (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        wd_tick,
  input  wire logic        debug_ack,
  input  wire logic        power_down,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             wdt_irq,
  output logic             chip_reset,
  output logic             wakeup_req
);
  import wdc_pkg::*;

  wdc_core_st_t s_r;
  wdc_core_st_t s_nxt;
  logic         timeout_p;
  logic         reset_p;
  logic         hit_ctrl;
  logic         hit_lock;
  logic         wr_ack;
  logic [31:0]  be_mask;
  logic [31:0]  wval;
  logic [31:0]  w1c;

  function automatic logic [31:0] ctrl_pack(input wdc_ctrl_t c);
    logic [31:0] v;
    v = '0;
    v[`WDC_B_DBG_DIS] = c.dbg_dis;
    v[`WDC_B_SEL_HI:`WDC_B_SEL_LO] = c.sel;
    v[`WDC_B_EN] = c.en;
    v[`WDC_B_IRQ_EN] = c.irq_en;
    v[`WDC_B_WK_FLAG] = c.wk_flag;
    v[`WDC_B_WK_EN] = c.wk_en;
    v[`WDC_B_IRQ_FLAG] = c.irq_flag;
    v[`WDC_B_RST_FLAG] = c.rst_flag;
    v[`WDC_B_RST_EN] = c.rst_en;
    v[`WDC_B_CLR] = c.clr;
    ctrl_pack = v;
  endfunction

  function automatic wdc_ctrl_t ctrl_unpack(input logic [31:0] v);
    wdc_ctrl_t c;
    c.dbg_dis = v[`WDC_B_DBG_DIS];
    c.sel = v[`WDC_B_SEL_HI:`WDC_B_SEL_LO];
    c.en = v[`WDC_B_EN];
    c.irq_en = v[`WDC_B_IRQ_EN];
    c.wk_flag = v[`WDC_B_WK_FLAG];
    c.wk_en = v[`WDC_B_WK_EN];
    c.irq_flag = v[`WDC_B_IRQ_FLAG];
    c.rst_flag = v[`WDC_B_RST_FLAG];
    c.rst_en = v[`WDC_B_RST_EN];
    c.clr = v[`WDC_B_CLR];
    ctrl_unpack = c;
  endfunction

  localparam wdc_ctrl_t CTRL_RST = ctrl_unpack(`WDC_CTRL_RESET);

  // word decode at the control offset
  assign hit_ctrl = avs_address[7:2] == 6'(`WDC_CTRL_OFS >> 2);
  assign hit_lock = avs_address[7:2] == 6'(`WDC_LOCK_OFS >> 2);
  assign wr_ack = avs_write && !s_r.wait_r;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wval = (ctrl_pack(s_r.ctrl) & ~be_mask) | (avs_writedata & be_mask);
  assign w1c = avs_writedata & be_mask;

  wdc_counter u_counter (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .wd_tick    (wd_tick),
    .enable     (s_r.ctrl.en),
    .clear      (s_r.ctrl.clr),
    .hold       (debug_ack && !s_r.ctrl.dbg_dis),
    .sel        (s_r.ctrl.sel),
    .rst_en     (s_r.ctrl.rst_en),
    .timeout_p  (timeout_p),
    .reset_p    (reset_p),
    .chip_reset (chip_reset)
  );

  always_comb begin
    s_nxt = s_r;
    // One wait cycle, then a single-cycle acknowledge
    s_nxt.wait_r = !((avs_read || avs_write) && s_r.wait_r);
    if (avs_read && s_r.wait_r) begin
      s_nxt.rdata = hit_ctrl ? ctrl_pack(s_r.ctrl) :
                    hit_lock ? {31'h0000_0000, s_r.unlocked} : 32'h0000_0000;
    end
    // self-clearing once the counter saw it
    if (s_r.ctrl.clr) begin
      s_nxt.ctrl.clr = 1'b0;
    end
    // lock gate on every writable bit
    if (wr_ack && hit_ctrl && s_r.unlocked) begin
      s_nxt.ctrl.dbg_dis = wval[`WDC_B_DBG_DIS];
      s_nxt.ctrl.sel = wval[`WDC_B_SEL_HI:`WDC_B_SEL_LO];
      s_nxt.ctrl.en = wval[`WDC_B_EN];
      s_nxt.ctrl.irq_en = wval[`WDC_B_IRQ_EN];
      s_nxt.ctrl.wk_en = wval[`WDC_B_WK_EN];
      s_nxt.ctrl.rst_en = wval[`WDC_B_RST_EN];
      if (w1c[`WDC_B_CLR]) begin
        s_nxt.ctrl.clr = 1'b1;
      end
      if (w1c[`WDC_B_WK_FLAG]) begin
        s_nxt.ctrl.wk_flag = 1'b0;
      end
      if (w1c[`WDC_B_IRQ_FLAG]) begin
        s_nxt.ctrl.irq_flag = 1'b0;
      end
      if (w1c[`WDC_B_RST_FLAG]) begin
        s_nxt.ctrl.rst_flag = 1'b0;
      end
    end
    // unlock sequence; any lock write with byte 0 enabled while open closes it
    if (wr_ack && hit_lock && avs_byteenable[0]) begin
      s_nxt.lk = LK_IDLE;
      if (s_r.unlocked) begin
        s_nxt.unlocked = 1'b0;
      end else begin
        unique case (s_r.lk)
          LK_IDLE: if (avs_writedata[7:0] == `WDC_UNLOCK_1) s_nxt.lk = LK_GOT1;
          LK_GOT1: if (avs_writedata[7:0] == `WDC_UNLOCK_2) s_nxt.lk = LK_GOT2;
          LK_GOT2: if (avs_writedata[7:0] == `WDC_UNLOCK_3) s_nxt.unlocked = 1'b1;
          default: s_nxt.lk = LK_IDLE;
        endcase
      end
    end
    // flag set at once, set beats a clear
    if (timeout_p) begin
      s_nxt.ctrl.irq_flag = 1'b1;
      if (s_r.ctrl.wk_en && power_down) begin
        s_nxt.ctrl.wk_flag = 1'b1;
      end
    end
    if (reset_p) begin
      s_nxt.ctrl.rst_flag = 1'b1;
    end
    s_nxt.irq = s_nxt.ctrl.irq_flag && s_nxt.ctrl.irq_en;
    s_nxt.wake = timeout_p && s_r.ctrl.wk_en && power_down;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{ctrl: CTRL_RST, lk: LK_IDLE, wait_r: 1'b1, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.wait_r;
  assign wdt_irq = s_r.irq;
  assign wakeup_req = s_r.wake;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence ctrl_write_locked;
    ce && wr_ack && hit_ctrl && !s_r.unlocked;
  endsequence

  chk_lock_gate: assert property (
    ctrl_write_locked |=> $stable(s_r.ctrl.en) && $stable(s_r.ctrl.sel))
    else $error("locked write changed control");

  chk_clr_self: assert property (
    (ce && s_r.ctrl.clr && !wr_ack) |=> !s_r.ctrl.clr)
    else $error("clear bit stuck");

  chk_irq_flag: assert property (
    (ce && timeout_p) |=> s_r.ctrl.irq_flag)
    else $error("timeout flag not set");

  chk_irq_gate: assert property (
    wdt_irq |-> s_r.ctrl.irq_en)
    else $error("irq without enable");

  chk_reserved_zero: assert property (
    (!s_r.wait_r && avs_read && hit_ctrl) |-> avs_readdata[30:11] == '0)
    else $error("reserved bits not zero");

  sequence bus_request_seen;
    ce && (avs_read || avs_write) && s_r.wait_r;
  endsequence

  chk_bus_answer: assert property (
    bus_request_seen |=> !avs_waitrequest)
    else $error("bus request not answered");

  chk_ack_single: assert property (
    (ce && !avs_waitrequest) |=> avs_waitrequest)
    else $error("acknowledge longer than one cycle");

  chk_unlock_order: assert property (
    $rose(s_r.unlocked) |-> $past(s_r.lk) == LK_GOT2)
    else $error("lock opened out of order");

  chk_rst_flag_set: assert property (
    (ce && reset_p) |=> s_r.ctrl.rst_flag)
    else $error("reset flag not set");

  chk_clr_capture: assert property (
    (ce && wr_ack && hit_ctrl && s_r.unlocked && w1c[`WDC_B_CLR]) |=> s_r.ctrl.clr)
    else $error("clear bit not captured");

  chk_flag_locked: assert property (
    (ce && s_r.ctrl.irq_flag && !(wr_ack && hit_ctrl && s_r.unlocked)) |=> s_r.ctrl.irq_flag)
    else $error("timeout flag cleared while locked");

endmodule

// File: src/wdc_cfg.svh
`ifndef WDC_CFG_SVH
`define WDC_CFG_SVH

`define WDC_BASE_ADDR   32'h4000_4000
`define WDC_CTRL_OFS    8'h00
`define WDC_LOCK_OFS    8'h04
`define WDC_CTRL_RESET  32'h0000_0700

`define WDC_B_DBG_DIS   31
`define WDC_B_SEL_HI    10
`define WDC_B_SEL_LO    8
`define WDC_B_EN        7
`define WDC_B_IRQ_EN    6
`define WDC_B_WK_FLAG   5
`define WDC_B_WK_EN     4
`define WDC_B_IRQ_FLAG  3
`define WDC_B_RST_FLAG  2
`define WDC_B_RST_EN    1
`define WDC_B_CLR       0

`define WDC_UNLOCK_1    8'h59
`define WDC_UNLOCK_2    8'h16
`define WDC_UNLOCK_3    8'h88

`define WDC_INTERVAL_MIN 19'h0_0010
`define WDC_DELAY_TICKS  11'h400
`define WDC_RST_TICKS    6'h3f

`endif

// File: src/wdc_pkg.sv
`include "wdc_cfg.svh"

package wdc_pkg;

  typedef enum logic [2:0] {
    ST_COUNT = 3'b001,
    ST_DELAY = 3'b010,
    ST_RESET = 3'b100
  } wdc_state_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_GOT1 = 3'b010,
    LK_GOT2 = 3'b100
  } wdc_lock_t;

  typedef struct packed {
    wdc_state_t  st;
    logic [18:0] cnt;
    logic [10:0] dly;
    logic [5:0]  rst_len;
    logic        timeout_p;
    logic        reset_p;
    logic        chip_reset;
  } wdc_cnt_st_t;

  typedef struct packed {
    logic        dbg_dis;
    logic [2:0]  sel;
    logic        en;
    logic        irq_en;
    logic        wk_flag;
    logic        wk_en;
    logic        irq_flag;
    logic        rst_flag;
    logic        rst_en;
    logic        clr;
  } wdc_ctrl_t;

  typedef struct packed {
    wdc_ctrl_t   ctrl;
    wdc_lock_t   lk;
    logic        unlocked;
    logic        wait_r;
    logic [31:0] rdata;
    logic        irq;
    logic        wake;
  } wdc_core_st_t;

  // Timeout length in watchdog periods for an interval code
  function automatic logic [18:0] wdc_interval(input logic [2:0] code);
    wdc_interval = `WDC_INTERVAL_MIN << {code, 1'b0};
  endfunction

endpackage

// File: src/wdc_counter.sv
`include "wdc_cfg.svh"

module wdc_counter (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       wd_tick,
  input  wire logic       enable,
  input  wire logic       clear,
  input  wire logic       hold,
  input  wire logic [2:0] sel,
  input  wire logic       rst_en,
  output logic            timeout_p,
  output logic            reset_p,
  output logic            chip_reset
);
  import wdc_pkg::*;

  wdc_cnt_st_t s_r;
  wdc_cnt_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.timeout_p = 1'b0;
    s_nxt.reset_p = 1'b0;
    if ((!enable || clear) && s_r.st != ST_RESET) begin
      s_nxt.st = ST_COUNT;
      s_nxt.cnt = '0;
      s_nxt.dly = '0;
    end else if (wd_tick) begin
      unique case (s_r.st)
        ST_COUNT: begin
          if (!hold) begin
            s_nxt.cnt = s_r.cnt + 19'h0_0001;
            // interval reached; >= covers a shortened select
            if (s_nxt.cnt >= wdc_interval(sel)) begin
              s_nxt.timeout_p = 1'b1;
              s_nxt.st = ST_DELAY;
              s_nxt.dly = '0;
            end
          end
        end
        ST_DELAY: begin
          if (!hold) begin
            s_nxt.dly = s_r.dly + 11'h001;
            if (s_nxt.dly == `WDC_DELAY_TICKS) begin
              s_nxt.cnt = '0;
              if (rst_en) begin
                s_nxt.reset_p = 1'b1;
                s_nxt.chip_reset = 1'b1;
                s_nxt.rst_len = '0;
                s_nxt.st = ST_RESET;
              end else begin
                s_nxt.st = ST_COUNT;
              end
            end
          end
        end
        ST_RESET: begin
          // pulse length; debug hold cannot stretch it
          s_nxt.rst_len = s_r.rst_len + 6'h01;
          if (s_nxt.rst_len == `WDC_RST_TICKS) begin
            s_nxt.chip_reset = 1'b0;
            s_nxt.st = ST_COUNT;
          end
        end
        default: s_nxt.st = ST_COUNT;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{st: ST_COUNT, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign timeout_p = s_r.timeout_p;
  assign reset_p = s_r.reset_p;
  assign chip_reset = s_r.chip_reset;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_debug_hold: assert property (
    (ce && wd_tick && hold && enable && !clear && s_r.st == ST_COUNT) |=> $stable(s_r.cnt))
    else $error("counter moved while held");

  chk_timeout_point: assert property (
    $rose(s_r.timeout_p) |-> s_r.cnt >= wdc_interval($past(sel)))
    else $error("timeout before interval");

  chk_delay_len: assert property (
    $rose(s_r.reset_p) |-> $past(s_r.dly) == `WDC_DELAY_TICKS - 11'h001)
    else $error("delay length wrong");

  chk_disable_zero: assert property (
    (ce && !enable && s_r.st != ST_RESET) |=> s_r.cnt == '0)
    else $error("counter not zeroed on disable");

  chk_reset_span: assert property (
    $rose(s_r.chip_reset) |-> s_r.rst_len == '0 && $past(rst_en))
    else $error("chip reset without enable");

  chk_reset_bound: assert property (
    s_r.chip_reset |-> s_r.rst_len < `WDC_RST_TICKS)
    else $error("chip reset too long");

endmodule

// File: verification/watchdog_control_register_bench.sv
`include "wdc_cfg.svh"

module watchdog_control_register_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] EN = 32'h0000_0080;
  localparam logic [31:0] IE = 32'h0000_0040;
  localparam logic [31:0] FL = 32'h0000_000c;
  localparam logic [31:0] RE = 32'h0000_0002;
  localparam logic [31:0] CL = 32'h0000_0001;
  localparam logic [31:0] DD = 32'h8000_0000;
  localparam logic [31:0] RW = 32'h8000_0752;
  localparam logic [7:0]  BAD_SEQ [4] = '{8'h59, 8'h00, 8'h16, 8'h88};
  logic        sys_clk = 0;
  logic        rst_b = 0;
  logic        ce = 1;
  logic        wd_tick = 1;
  logic        debug_ack = 0;
  logic        power_down = 0;
  logic [7:0]  avs_address = '0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        wdt_irq;
  logic        chip_reset;
  logic        wakeup_req;
  logic [31:0] q;
  logic [31:0] d;
  bit          tick_rnd = 0;
  int          err_count = 0;
  int          checks_done = 0;

  wdc_core uut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .wd_tick(wd_tick),
    .debug_ack(debug_ack), .power_down(power_down), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wdt_irq(wdt_irq), .chip_reset(chip_reset),
    .wakeup_req(wakeup_req));

  always #25 sys_clk = ~sys_clk;
  // Random ticks stretch the watchdog clock against the bus clock
  always @(posedge sys_clk) wd_tick <= tick_rnd ? 1'($urandom_range(1)) : 1'b1;

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= dat;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      $display("MISMATCH at %0t: bus timeout", $time);
      summarize();
    end
  endtask

  // Ticks until irq (s=0), chip reset (s=1) or wake pulse (s=2) reaches lvl
  task automatic wait_for(input int s, input logic lvl, input int lo, input int hi,
                          input string what);
    int   t;
    int   n;
    logic v;
    t = 0;
    n = 0;
    do begin
      @(negedge sys_clk);
      t += int'(wd_tick);
      n++;
      v = (s == 2) ? wakeup_req : (s == 1) ? chip_reset : wdt_irq;
    end while (v !== lvl && n < 8 * hi + 50);
    if (v !== lvl) begin
      err_count++;
      $display("MISMATCH at %0t: %s timeout", $time, what);
      summarize();
    end
    chk(32'(t >= lo && t <= hi), 32'h1, what);
  endtask

  function automatic int ivl(input int code);
    return 1 << (4 + 2 * code);
  endfunction

  initial begin
    void'($urandom(32'ha4701106));
    repeat (10) @(posedge sys_clk);
    rst_b <= 1;
    @(posedge sys_clk);
    bus(0, `WDC_CTRL_OFS, 0);
    chk(q, `WDC_CTRL_RESET, "reset value");
    bus(0, 8'h08, 0);
    chk(q, 32'h0, "unmapped read");
    bus(1, `WDC_CTRL_OFS, 32'h8000_0783);
    bus(0, `WDC_CTRL_OFS, 0);
    chk(q, `WDC_CTRL_RESET, "locked write");
    // A stray byte must restart the unlock sequence
    foreach (BAD_SEQ[i]) bus(1, `WDC_LOCK_OFS, 32'(BAD_SEQ[i]));
    bus(0, `WDC_LOCK_OFS, 0);
    chk(32'(q[0]), 32'h0, "bad sequence");
    bus(1, `WDC_LOCK_OFS, 32'h0000_0059);
    bus(1, `WDC_LOCK_OFS, 32'h0000_0016);
    bus(1, `WDC_LOCK_OFS, 32'h0000_0088);
    bus(0, `WDC_LOCK_OFS, 0);
    chk(32'(q[0]), 32'h1, "unlocked");
    repeat (8) begin
      d = $urandom & ~EN;
      bus(1, `WDC_CTRL_OFS, d);
      bus(0, `WDC_CTRL_OFS, 0);
      chk(q, d & RW, "random write");
    end
    tick_rnd = 1;
    for (int c = 0; c < 3; c++) begin
      bus(1, `WDC_CTRL_OFS, EN | IE | RE | CL | (32'(c) << `WDC_B_SEL_LO));
      wait_for(0, 1, ivl(c) - 3, ivl(c) + 4, "interval");
      wait_for(1, 1, 1020, 1028, "delay");
      wait_for(1, 0, 61, 65, "reset length");
      bus(0, `WDC_CTRL_OFS, 0);
      chk(q & FL, FL, "flags set");
      bus(1, `WDC_CTRL_OFS, FL);
      bus(0, `WDC_CTRL_OFS, 0);
      chk(q, 32'h0, "disabled");
    end
    bus(1, `WDC_CTRL_OFS, EN);
    repeat (60) @(negedge sys_clk);
    chk(32'(wdt_irq), 32'h0, "irq masked");
    bus(0, `WDC_CTRL_OFS, 0);
    chk(q & FL, 32'h8, "flag unmasked");
    bus(1, `WDC_CTRL_OFS, FL);
    tick_rnd = 0;
    for (int k = 0; k < 2; k++) begin
      bus(1, `WDC_CTRL_OFS, EN | IE | 32'h100);
      repeat (40) @(posedge sys_clk);
      if (k == 0) begin
        bus(1, `WDC_CTRL_OFS, EN | IE | CL | 32'h100);
      end else begin
        bus(1, `WDC_CTRL_OFS, 32'h100);
        bus(1, `WDC_CTRL_OFS, EN | IE | 32'h100);
      end
      wait_for(0, 1, 60, 67, "restart");
      bus(1, `WDC_CTRL_OFS, FL);
    end
    tick_rnd = 1;
    debug_ack <= 1;
    bus(1, `WDC_CTRL_OFS, EN | IE);
    repeat (60) @(negedge sys_clk);
    chk(32'(wdt_irq), 32'h0, "debug hold");
    @(posedge sys_clk);
    debug_ack <= 0;
    wait_for(0, 1, 13, 20, "hold release");
    bus(1, `WDC_CTRL_OFS, FL);
    debug_ack <= 1;
    bus(1, `WDC_CTRL_OFS, EN | IE | DD);
    wait_for(0, 1, 13, 20, "hold disabled");
    bus(1, `WDC_CTRL_OFS, FL);
    debug_ack <= 0;
    // Wake pulse and flag only while powered down
    power_down <= 1;
    bus(1, `WDC_CTRL_OFS, EN | 32'h0000_0010);
    wait_for(2, 1, 13, 20, "wakeup");
    bus(0, `WDC_CTRL_OFS, 0);
    chk(q & 32'h0000_0028, 32'h0000_0028, "wake flag");
    power_down <= 0;
    bus(1, `WDC_CTRL_OFS, FL | 32'h0000_0020);
    bus(1, `WDC_LOCK_OFS, 0);
    bus(1, `WDC_CTRL_OFS, EN | RE);
    bus(0, `WDC_CTRL_OFS, 0);
    chk(q, 32'h0, "relocked");
    summarize();
  end

  initial begin
    #2500000;
    err_count++;
    summarize();
  end
endmodule
